// ### design/lgc_pkg.sv
package lgc_pkg;

  localparam int SHIFT_W    = 257;
  localparam int DATA_W     = 256;
  localparam int SEL_BIT    = 256;
  localparam int CHANNELS   = 16;
  localparam int GRAY_W     = 16;
  localparam int DOT_W      = 7;
  localparam int DOT_ALL_W  = 112;
  localparam int BRIGHT_LSB = 112;
  localparam int BRIGHT_W   = 7;
  localparam int RETIME_BIT = 119;
  localparam int CTL_W      = 120;

  localparam logic [15:0] GRAY_MAX  = 16'hffff;
  localparam logic [15:0] GRAY_ZERO = 16'h0000;
  localparam logic [15:0] GRAY_STEP = 16'h0001;

  localparam int ADDR_W = 4;
  localparam int BUS_W  = 32;
  localparam logic [3:0] REG_STATUS  = 4'h0;
  localparam logic [3:0] REG_MASK    = 4'h4;
  localparam logic [3:0] REG_COUNT   = 4'h8;
  localparam logic [3:0] REG_CONTROL = 4'hc;

  localparam int ST_W          = 4;
  localparam int ST_REF_SHORT  = 0;
  localparam int ST_GRAY_LATCH = 1;
  localparam int ST_CTL_LATCH  = 2;
  localparam int ST_WRAP       = 3;
  localparam logic [3:0] STATUS_RST = 4'h0;
  localparam logic [3:0] MASK_RST   = 4'h0;

  localparam int CTRL_RETIME_BIT = 0;
  localparam int CTRL_BRIGHT_LSB = 8;

  localparam int PIN_W        = 4;
  localparam int PIN_GRAY_CLK = 0;
  localparam int PIN_BLANK    = 1;
  localparam int PIN_LATCH    = 2;
  localparam int PIN_SHORT    = 3;
  localparam logic [3:0] PIN_RST = 4'h0;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } lgc_bus_req_s;

endpackage

// ### design/lgc_pin_sync.sv
`timescale 1ns/10ps
module lgc_pin_sync (
  input  wire logic                     sys_clk_in,
  input  wire logic                     sys_rst_in,
  input  wire logic [lgc_pkg::PIN_W-1:0] pins_in,
  output logic      [lgc_pkg::PIN_W-1:0] level_out,
  output logic      [lgc_pkg::PIN_W-1:0] rise_out
);

  logic [lgc_pkg::PIN_W-1:0] stage1;
  logic [lgc_pkg::PIN_W-1:0] stage2;
  logic [lgc_pkg::PIN_W-1:0] stage3;

  // The first stage feeds only the second one, so a metastable value never fans out.
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      stage1 <= lgc_pkg::PIN_RST;
      stage2 <= lgc_pkg::PIN_RST;
      stage3 <= lgc_pkg::PIN_RST;
    end
    else
    begin
      stage1 <= pins_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  assign level_out = stage2;
  assign rise_out  = stage2 & ~stage3;

endmodule

// ### design/lgc_led_core.sv
`timescale 1ns/10ps
// Function
// - With blank low, each grayscale clock rising edge advances the counter by one.
// - With blank high, all sixteen sink outputs are held off.
// - With blank high, the counter is cleared to zero and PWM timing restarts.
// - Reference pin short forces all sinks off and sets the short flag.
// - Latch strobe rise with select bit zero loads the first grayscale latch.
// - Latch strobe rise with select bit one loads the first control latch.
// - Timing reset bit set: grayscale latch strobe reinitialises the counter.
// - Timing reset bit set: grayscale strobe loads first and second grayscale latches.
// - Timing reset bit set: same strobe copies dot correction and brightness onward.
module lgc_led_core (
  input  wire logic                           sys_clk_in,
  input  wire logic                           sys_rst_in,
  input  wire logic                           grayscale_clock_in,
  input  wire logic                           blank_in,
  input  wire logic                           latch_strobe_in,
  input  wire logic                           reference_short_in,
  input  wire logic [lgc_pkg::SHIFT_W-1:0]    common_shift_in,
  input  wire lgc_pkg::lgc_bus_req_s          bus_req_in,
  output logic      [lgc_pkg::BUS_W-1:0]      bus_rdata_out,
  output logic      [lgc_pkg::CHANNELS-1:0]   sink_output_out,
  output logic      [lgc_pkg::DOT_ALL_W-1:0]  dot_correction_out,
  output logic      [lgc_pkg::BRIGHT_W-1:0]   global_brightness_out,
  output logic      [lgc_pkg::GRAY_W-1:0]     grayscale_count_out,
  output logic                                irq_out
);

  logic [lgc_pkg::PIN_W-1:0]    pin_level;
  logic [lgc_pkg::PIN_W-1:0]    pin_rise;
  logic                         gray_clk_rise;
  logic                         blank_lvl;
  logic                         latch_rise;
  logic                         short_lvl;
  logic [lgc_pkg::DATA_W-1:0]   gray_latch1;
  logic [lgc_pkg::DATA_W-1:0]   gray_latch2;
  logic [lgc_pkg::CTL_W-1:0]    ctl_latch1;
  logic [lgc_pkg::CTL_W-1:0]    ctl_latch2;
  logic [lgc_pkg::GRAY_W-1:0]   gray_count;
  logic [lgc_pkg::ST_W-1:0]     status;
  logic [lgc_pkg::ST_W-1:0]     mask;
  logic [lgc_pkg::ST_W-1:0]     status_set;
  logic [lgc_pkg::ST_W-1:0]     status_clr;
  logic [lgc_pkg::CHANNELS-1:0] next_sink;
  logic [lgc_pkg::BUS_W-1:0]    next_rdata;
  logic                         timing_reset;
  logic                         gray_write;
  logic                         ctl_write;
  logic                         gray_retime;
  logic                         advance;
  logic                         wrap;

  function automatic logic [lgc_pkg::GRAY_W-1:0] gray_slice(
    input logic [lgc_pkg::DATA_W-1:0] vec,
    input int                         ch
  );
    gray_slice = vec[ch*lgc_pkg::GRAY_W +: lgc_pkg::GRAY_W];
  endfunction

  function automatic logic [lgc_pkg::DOT_ALL_W-1:0] dot_field(
    input logic [lgc_pkg::CTL_W-1:0] vec
  );
    dot_field = vec[lgc_pkg::DOT_ALL_W-1:0];
  endfunction

  function automatic logic [lgc_pkg::BRIGHT_W-1:0] bright_field(
    input logic [lgc_pkg::CTL_W-1:0] vec
  );
    bright_field = vec[lgc_pkg::BRIGHT_LSB +: lgc_pkg::BRIGHT_W];
  endfunction

  // All four pins are asynchronous to the system clock and pass two flops first.
  lgc_pin_sync u_sync (
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .pins_in    ({reference_short_in, latch_strobe_in, blank_in, grayscale_clock_in}),
    .level_out  (pin_level),
    .rise_out   (pin_rise)
  );

  assign gray_clk_rise = pin_rise[lgc_pkg::PIN_GRAY_CLK];
  assign blank_lvl     = pin_level[lgc_pkg::PIN_BLANK];
  assign latch_rise    = pin_rise[lgc_pkg::PIN_LATCH];
  assign short_lvl     = pin_level[lgc_pkg::PIN_SHORT];
  assign timing_reset  = ctl_latch1[lgc_pkg::RETIME_BIT];
  // The shifter is trusted to hold a whole frame when the strobe rises.
  assign gray_write    = latch_rise & ~common_shift_in[lgc_pkg::SEL_BIT];
  assign ctl_write     = latch_rise & common_shift_in[lgc_pkg::SEL_BIT];
  assign gray_retime   = gray_write & timing_reset;
  assign advance       = gray_clk_rise & ~blank_lvl;
  assign wrap          = advance & (gray_count == lgc_pkg::GRAY_MAX);

  // First-stage latches take the common shift register on the strobe.
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      gray_latch1 <= '0;
      ctl_latch1  <= '0;
    end
    else
    begin
      if (gray_write)
      begin
        gray_latch1 <= common_shift_in[lgc_pkg::DATA_W-1:0];
      end
      if (ctl_write)
      begin
        ctl_latch1 <= common_shift_in[lgc_pkg::CTL_W-1:0];
      end
    end
  end

  // Second stage refreshes at the end of each PWM cycle so a running period never tears;
  // the timing reset path loads it at once instead.
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      gray_latch2 <= '0;
      ctl_latch2  <= '0;
    end
    else if (gray_retime)
    begin
      gray_latch2 <= common_shift_in[lgc_pkg::DATA_W-1:0];
      ctl_latch2  <= ctl_latch1;
    end
    else if (wrap)
    begin
      gray_latch2 <= gray_latch1;
      ctl_latch2 <= ctl_latch1;
    end
  end

  // Blank wins over the timing reset, which wins over counting.
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      gray_count <= lgc_pkg::GRAY_ZERO;
    end
    else if (blank_lvl)
    begin
      gray_count <= lgc_pkg::GRAY_ZERO;
    end
    else if (gray_retime)
    begin
      gray_count <= lgc_pkg::GRAY_ZERO;
    end
    else if (advance)
    begin
      gray_count <= gray_count + lgc_pkg::GRAY_STEP;
    end
  end

  always_comb
  begin
    next_sink = '0;
    for (int ch = 0; ch < lgc_pkg::CHANNELS; ch++)
    begin
      next_sink[ch] = gray_count < gray_slice(gray_latch2, ch);
    end
    if (blank_lvl || short_lvl)
    begin
      next_sink = '0;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      sink_output_out <= '0;
    end
    else
    begin
      sink_output_out <= next_sink;
    end
  end

  assign dot_correction_out    = dot_field(ctl_latch2);
  assign global_brightness_out = bright_field(ctl_latch2);
  assign grayscale_count_out   = gray_count;

  always_comb
  begin
    status_set = '0;
    status_set[lgc_pkg::ST_REF_SHORT]  = short_lvl;
    status_set[lgc_pkg::ST_GRAY_LATCH] = gray_write;
    status_set[lgc_pkg::ST_CTL_LATCH]  = ctl_write;
    status_set[lgc_pkg::ST_WRAP]       = wrap;
    status_clr = '0;
    if (bus_req_in.wr && bus_req_in.addr == lgc_pkg::REG_STATUS)
    begin
      status_clr = bus_req_in.wdata[lgc_pkg::ST_W-1:0];
    end
  end

  // A new event in the clearing cycle survives because the set term is applied last.
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      status <= lgc_pkg::STATUS_RST;
    end
    else
    begin
      status <= (status & ~status_clr) | status_set;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      mask <= lgc_pkg::MASK_RST;
    end
    else if (bus_req_in.wr && bus_req_in.addr == lgc_pkg::REG_MASK)
    begin
      mask <= bus_req_in.wdata[lgc_pkg::ST_W-1:0];
    end
  end

  assign irq_out = |(status & mask);

  always_comb
  begin
    next_rdata = '0;
    case (bus_req_in.addr)
      lgc_pkg::REG_STATUS:
      begin
        next_rdata[lgc_pkg::ST_W-1:0] = status;
      end
      lgc_pkg::REG_MASK:
      begin
        next_rdata[lgc_pkg::ST_W-1:0] = mask;
      end
      lgc_pkg::REG_COUNT:
      begin
        next_rdata[lgc_pkg::GRAY_W-1:0] = gray_count;
      end
      lgc_pkg::REG_CONTROL:
      begin
        next_rdata[lgc_pkg::CTRL_RETIME_BIT] = timing_reset;
        next_rdata[lgc_pkg::CTRL_BRIGHT_LSB +: lgc_pkg::BRIGHT_W] = bright_field(ctl_latch1);
      end
      default:
      begin
        next_rdata = '0;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe and is zero otherwise.
  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      bus_rdata_out <= '0;
    end
    else if (bus_req_in.rd)
    begin
      bus_rdata_out <= next_rdata;
    end
    else
    begin
      bus_rdata_out <= '0;
    end
  end

  count_advance_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    advance && !gray_retime |=> gray_count == $past(gray_count) + lgc_pkg::GRAY_STEP)
    else $error("Grayscale counter did not advance by one.");

  blank_outputs_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    blank_lvl |=> sink_output_out == '0)
    else $error("Sink output on while blank high.");

  blank_clear_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    blank_lvl [*2] |=> gray_count == lgc_pkg::GRAY_ZERO && sink_output_out == '0)
    else $error("Counter not held at zero under blank.");

  short_flag_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    short_lvl |=> status[lgc_pkg::ST_REF_SHORT] && sink_output_out == '0)
    else $error("Reference short did not force off and flag.");

  gray_latch_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    gray_write |=> gray_latch1 == $past(common_shift_in[lgc_pkg::DATA_W-1:0])
                   && ctl_latch1 == $past(ctl_latch1))
    else $error("Grayscale latch load wrong.");

  ctl_latch_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    ctl_write |=> ctl_latch1 == $past(common_shift_in[lgc_pkg::CTL_W-1:0])
                  && gray_latch1 == $past(gray_latch1))
    else $error("Control latch load wrong.");

  timing_reset_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    gray_retime |=> gray_count == lgc_pkg::GRAY_ZERO)
    else $error("Timing reset did not clear the counter.");

  both_latches_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    gray_retime |=> gray_latch2 == gray_latch1
                    && gray_latch2 == $past(common_shift_in[lgc_pkg::DATA_W-1:0]))
    else $error("Second grayscale latch not loaded with the first.");

  dot_copy_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    gray_retime |=> dot_correction_out == $past(dot_field(ctl_latch1))
                    && global_brightness_out == $past(bright_field(ctl_latch1)))
    else $error("Dot correction or brightness not copied.");

  no_retime_a: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    gray_write && !timing_reset && !wrap |=> gray_latch2 == $past(gray_latch2))
    else $error("Second latch changed without timing reset.");

endmodule

// ### test/lgc_ctrl_model.sv
`timescale 1ns/10ps
module lgc_ctrl_model (
  input  wire logic                        clk_in,
  output logic                             gray_clk_out,
  output logic                             blank_out,
  output logic                             latch_out,
  output logic [lgc_pkg::SHIFT_W-1:0]      shift_out
);
  initial
  begin
    gray_clk_out = 1'b0;
    blank_out = 1'b0;
    latch_out = 1'b0;
    shift_out = '0;
  end
  task automatic set_blank(input logic v);
    blank_out <= v;
  endtask
  // Width w lets one run act as a fast or a slow controller.
  task automatic pulses(input int n, input int w);
    repeat (n)
    begin
      gray_clk_out <= 1'b1;
      repeat (w) @(posedge clk_in);
      gray_clk_out <= 1'b0;
      repeat (w) @(posedge clk_in);
    end
  endtask
  // The whole frame stands before the strobe rises.
  task automatic load(input logic [lgc_pkg::SHIFT_W-1:0] frame);
    shift_out <= frame;
    @(posedge clk_in);
    latch_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    latch_out <= 1'b0;
    repeat (3) @(posedge clk_in);
    // The next frame is already shifting in, so stale data must not be relatched.
    shift_out <= ~frame;
    repeat (2) @(posedge clk_in);
  endtask
endmodule

// ### test/lgc_led_core_tb.sv
`timescale 1ns/10ps
module lgc_led_core_tb;
  logic                        sys_clk_in;
  logic                        sys_rst_in;
  logic                        short_pin;
  logic                        gray_clk;
  logic                        blank;
  logic                        latch;
  logic [lgc_pkg::SHIFT_W-1:0] shift;
  lgc_pkg::lgc_bus_req_s       req;
  logic [31:0]                 rdata;
  logic [15:0]                 sinks;
  logic [111:0]                dot_out;
  logic [6:0]                  bright_out;
  logic [15:0]                 count;
  logic                        irq;
  logic [31:0]                 exp_q[$];
  logic                        rd_pend;
  int                          errors;
  int                          comparisons;
  int                          n;
  logic [111:0]                dot;
  logic [6:0]                  bright;
  logic [lgc_pkg::SHIFT_W-1:0] frame;
  logic [15:0]                 want;

  initial
  begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  lgc_led_core uut (
    .sys_clk_in            (sys_clk_in),
    .sys_rst_in            (sys_rst_in),
    .grayscale_clock_in    (gray_clk),
    .blank_in              (blank),
    .latch_strobe_in       (latch),
    .reference_short_in    (short_pin),
    .common_shift_in       (shift),
    .bus_req_in            (req),
    .bus_rdata_out         (rdata),
    .sink_output_out       (sinks),
    .dot_correction_out    (dot_out),
    .global_brightness_out (bright_out),
    .grayscale_count_out   (count),
    .irq_out               (irq)
  );

  lgc_ctrl_model ctl (
    .clk_in       (sys_clk_in),
    .gray_clk_out (gray_clk),
    .blank_out    (blank),
    .latch_out    (latch),
    .shift_out    (shift)
  );

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge sys_clk_in);
  endtask

  // A gap cycle after each strobe keeps one assignment per signal per step.
  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [31:0] d);
    req <= '{addr: a, wdata: d, wr: w, rd: r};
    @(posedge sys_clk_in);
    req <= '0;
    @(posedge sys_clk_in);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 32'h0);
  endtask

  always @(posedge sys_clk_in)
  begin
    if (rd_pend)
      chk(rdata, exp_q.pop_front());
    rd_pend <= req.rd;
  end

  task automatic complete_run;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    idle(20000);
    errors++;
    complete_run;
  end

  initial
  begin
    sys_rst_in = 1'b1;
    short_pin = 1'b0;
    req = '0;
    rd_pend = 1'b0;
    errors = 0;
    comparisons = 0;
    n = $urandom(18765);
    idle(10);
    sys_rst_in <= 1'b0;
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h0);
    bus(1'b1, 1'b0, 4'h2, 32'hffffffff);
    rd(4'h2, 32'h0);
    n = 3 + $urandom % 6;
    ctl.pulses(n, 2 + $urandom % 3);
    idle(2);
    rd(4'h8, 32'(n));
    ctl.set_blank(1'b1);
    idle(5);
    rd(4'h8, 32'h0);
    ctl.load({1'b0, {256{1'b1}}});
    bright = 7'($urandom());
    dot = {$urandom(), $urandom(), $urandom(), 16'($urandom())};
    ctl.load({1'b1, 136'h0, 1'b1, bright, dot});
    rd(4'hc, {17'h0, bright, 7'h0, 1'b1});
    rd(4'h0, 32'h6);
    chk(dot_out, 128'h0);
    ctl.set_blank(1'b0);
    idle(4);
    ctl.pulses(4, 2);
    // Without the timing reset the second grayscale latch must keep its zeros.
    chk(sinks, 128'h0);
    frame = '0;
    for (int c = 0; c < 16; c++)
      frame[16*c +: 16] = 16'(c);
    ctl.load(frame);
    rd(4'h8, 32'h0);
    chk(dot_out, dot);
    chk(bright_out, bright);
    rd(4'h0, 32'h6);
    n = 1 + $urandom % 15;
    ctl.pulses(n, 2);
    idle(2);
    for (int c = 0; c < 16; c++)
      want[c] = (n < c);
    chk(sinks, want);
    ctl.set_blank(1'b1);
    idle(5);
    chk(sinks, 128'h0);
    chk(count, 128'h0);
    ctl.set_blank(1'b0);
    idle(4);
    ctl.pulses(2, 2);
    idle(2);
    chk(sinks, 128'hfff8);
    short_pin <= 1'b1;
    idle(6);
    chk(sinks, 128'h0);
    chk(irq, 128'h0);
    bus(1'b1, 1'b0, 4'h4, 32'h1);
    chk(irq, 128'h1);
    rd(4'h0, 32'h7);
    short_pin <= 1'b0;
    idle(5);
    bus(1'b1, 1'b0, 4'h0, 32'hf);
    rd(4'h0, 32'h0);
    chk(irq, 128'h0);
    idle(3);
    complete_run;
  end
endmodule
